// ---- hw/pwr_seq_device.sv ----
/*
 * device end: power-off, software reset and hardware reset sequencing,
 * plus low-power idle and rtc gating on the slow clock.
 * assumes the host end drives commands one at a time and main_supply is a level.
 */
`timescale 1ns/100ps
`default_nettype none

module pwr_seq_device
    import pwr_seq_pkg::*;
#(
    parameter bit VARIANT_TWO = 1'b0,            // 0: core-only reset, 1: core and pmu reset
    parameter bit HAS_SLOW_CLK_IN = 1'b1,        // slow clock input fitted
    parameter bit SLOW_FROM_OWN_OUT = 1'b0,      // slow clock fed from own output
    parameter int unsigned SLOW_TIMEOUT = SLOW_CLK_TIMEOUT_CYC // cycles allowed between slow edges
)
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // link to host
    pwr_seq_if.device link,
    // user-side status
    output logic [2:0] mode_out,
    output logic core_reset_out,
    output logic pmu_reset_out,
    output logic save_settings_out,
    output logic low_power_idle_out,
    output logic rtc_running_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        mode_t mode;                 // power mode
        logic [CNT_W-1:0] rst_cnt;   // reset low length
        logic [CNT_W-1:0] pon_cnt;   // power-on low length
        logic [CNT_W-1:0] seq_cnt;   // routine progress
        logic [CNT_W-1:0] slow_cnt;  // cycles since slow clock edge
        logic slow_prev;             // last slow clock sample
        logic slow_ok;               // slow clock seen recently
        logic psave_en;              // power saving enabled
        logic ok;                    // OK answer pulse
        logic rst_done;              // reset low already acted on
    } state_t;

    state_t s_r;
    state_t s_nxt;
    logic rst_qual;                  // qualifying reset low length reached
    logic pon_qual;                  // qualifying power-on low length reached
    logic slow_present;              // effective 32 kHz availability

    assign rst_qual = (s_r.rst_cnt >= CNT_W'(RESET_MIN_CYC));
    assign pon_qual = (s_r.pon_cnt >= CNT_W'(POWER_ON_MIN_CYC));
    // without an input the internal oscillator always runs
    assign slow_present = HAS_SLOW_CLK_IN ? s_r.slow_ok : 1'b1;

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.ok = 1'b0;
        // reset pin length counter, saturating
        if (link.hw_reset_level)
        begin
            s_nxt.rst_cnt = '0;
            s_nxt.rst_done = 1'b0;
        end
        else if (s_r.rst_cnt != '1)
        begin
            s_nxt.rst_cnt = s_r.rst_cnt + CNT_W'(1);
        end
        // power-on pin length counter
        if (link.power_on_level)
            s_nxt.pon_cnt = '0;
        else if (s_r.pon_cnt != '1)
            s_nxt.pon_cnt = s_r.pon_cnt + CNT_W'(1);
        // slow clock watchdog: any edge restarts it
        s_nxt.slow_prev = link.slow_clock_input;
        if (link.slow_clock_input != s_r.slow_prev)
        begin
            s_nxt.slow_cnt = '0;
            s_nxt.slow_ok = 1'b1;
        end
        else if (s_r.slow_cnt >= CNT_W'(SLOW_TIMEOUT))
        begin
            s_nxt.slow_ok = 1'b0;        // too slow or stopped
        end
        else
        begin
            s_nxt.slow_cnt = s_r.slow_cnt + CNT_W'(1);
        end
        // mode sequencing
        unique case (s_r.mode)
            MODE_NOT_POWERED:
            begin
                if (link.main_supply)
                    s_nxt.mode = MODE_POWER_OFF;
            end
            MODE_ACTIVE:
            begin
                if (rst_qual && !s_r.rst_done)
                begin
                    s_nxt.mode = MODE_HW_RESET;
                    s_nxt.rst_done = 1'b1;
                end
                else if (link.cmd_valid && link.cmd_code == CMD_POWER_OFF)
                begin
                    s_nxt.mode = MODE_SWITCH_OFF;
                    s_nxt.seq_cnt = '0;
                    s_nxt.ok = 1'b1;
                end
                else if (link.cmd_valid && link.cmd_code == CMD_FUNC_RESET)
                begin
                    s_nxt.mode = MODE_SW_RESET;
                    s_nxt.seq_cnt = '0;
                    s_nxt.ok = 1'b1;
                end
                else if (link.cmd_valid && link.cmd_code == CMD_POWER_SAVE)
                begin
                    s_nxt.psave_en = 1'b1;
                    s_nxt.ok = 1'b1;
                end
            end
            MODE_SWITCH_OFF, MODE_SW_RESET:
            begin
                // save settings and detach before acting
                if (s_r.seq_cnt == CNT_W'(SAVE_CYC - 1))
                    s_nxt.mode = (s_r.mode == MODE_SWITCH_OFF) ? MODE_POWER_OFF : MODE_ACTIVE;
                else
                    s_nxt.seq_cnt = s_r.seq_cnt + CNT_W'(1);
            end
            MODE_POWER_OFF:
            begin
                if (!link.main_supply)
                    s_nxt.mode = MODE_NOT_POWERED;
                else if (pon_qual || (rst_qual && !s_r.rst_done))
                begin
                    s_nxt.mode = MODE_ACTIVE;
                    s_nxt.rst_done = !link.hw_reset_level;
                end
            end
            MODE_HW_RESET:
            begin
                // held while the pin stays low, no save
                if (link.hw_reset_level)
                    s_nxt.mode = MODE_ACTIVE;
            end
            default:
                s_nxt.mode = MODE_NOT_POWERED;
        endcase
        // pmu reset on variant two clears the saving setting
        if (s_nxt.mode == MODE_HW_RESET && VARIANT_TWO)
            s_nxt.psave_en = 1'b0;
        if (!link.main_supply)
            s_nxt.mode = MODE_NOT_POWERED;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            s_r <= '{mode: MODE_NOT_POWERED, default: '0};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_comb
    begin
        link.cmd_ok = s_r.ok;
        // rail on while active, in routines and in variant-one reset
        link.vint_on = (s_r.mode == MODE_ACTIVE) || (s_r.mode == MODE_SWITCH_OFF) ||
            (s_r.mode == MODE_SW_RESET) || (s_r.mode == MODE_HW_RESET && !VARIANT_TWO);
        link.backup_rtc_supply = (s_r.mode != MODE_NOT_POWERED);
        link.pins_tristate = !link.vint_on;
        link.pins_reset_state = (s_r.mode == MODE_HW_RESET) && !VARIANT_TWO;
    end

    assign mode_out = s_r.mode;
    assign core_reset_out = (s_r.mode == MODE_HW_RESET);
    assign pmu_reset_out = (s_r.mode == MODE_HW_RESET) && VARIANT_TWO;
    assign save_settings_out = (s_r.mode == MODE_SWITCH_OFF) || (s_r.mode == MODE_SW_RESET);
    assign low_power_idle_out = (s_r.mode == MODE_ACTIVE) && s_r.psave_en && slow_present;
    // own output feeds only while switched on; rtc keeps power in reset
    assign rtc_running_out = slow_present && (s_r.mode != MODE_NOT_POWERED) &&
        !(SLOW_FROM_OWN_OUT && HAS_SLOW_CLK_IN && s_r.mode == MODE_POWER_OFF);

endmodule : pwr_seq_device

`default_nettype wire

// ---- hw/pwr_seq_pkg.sv ----
/*
 * constants and types shared by the power-off / reset sequencer ends.
 * assumes both ends run on one 125 MHz clock with a synchronous active-low reset.
 */
package pwr_seq_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 8;          // 125 MHz
    localparam int unsigned RESET_MIN_NS = 400;         // least qualifying reset low time
    localparam int unsigned RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned POWER_ON_MIN_NS = 400;      // least qualifying power-on low time
    localparam int unsigned POWER_ON_MIN_CYC = (POWER_ON_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SAVE_CYC = 16;              // settings save + detach duration
    localparam int unsigned SLOW_CLK_TIMEOUT_CYC = 8192; // slow clock must toggle within this
    localparam int unsigned CNT_W = 16;                 // width of the device and host cycle counters

    // ------------------------------------------------------------
    // commands from host
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CMD_NONE,
        CMD_POWER_OFF,
        CMD_FUNC_RESET,
        CMD_POWER_SAVE
    } cmd_t;

    // ------------------------------------------------------------
    // device power modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_NOT_POWERED,
        MODE_ACTIVE,
        MODE_SWITCH_OFF,
        MODE_POWER_OFF,
        MODE_SW_RESET,
        MODE_HW_RESET
    } mode_t;

endpackage : pwr_seq_pkg

// ---- hw/pwr_seq_if.sv ----
/*
 * link between the host end and the device end of the sequencer.
 * resolves the pulled-up reset and power-on wires itself from the host enables.
 */
`timescale 1ns/100ps
`default_nettype none

interface pwr_seq_if;
    import pwr_seq_pkg::*;

    // command channel
    logic cmd_valid;                // host command strobe, one cycle
    cmd_t cmd_code;                 // command code
    logic cmd_ok;                   // device OK answer, one cycle
    // pulled-up host-driven pins: drive low while enable is high
    logic hw_reset_oe;              // host pulls reset low
    logic power_on_oe;              // host pulls power-on low
    logic hw_reset_level;           // resolved level seen by device
    logic power_on_level;           // resolved level seen by device
    // supplies and pins
    logic vint_on;                  // interface supply rail
    logic backup_rtc_supply;        // backup supply state
    logic pins_tristate;            // digital pins tri-stated
    logic pins_reset_state;         // digital pins held in reset state
    logic main_supply;              // main supply present
    logic slow_clock_input;         // 32 kHz reference

    assign hw_reset_level = ~hw_reset_oe;   // internal pull-up keeps it high
    assign power_on_level = ~power_on_oe;   // external pull-up keeps it high

    modport device (
        input cmd_valid, cmd_code, hw_reset_level, power_on_level, main_supply, slow_clock_input,
        output cmd_ok, vint_on, backup_rtc_supply, pins_tristate, pins_reset_state
    );
    modport host (
        output cmd_valid, cmd_code, hw_reset_oe, power_on_oe,
        input cmd_ok, vint_on
    );
endinterface : pwr_seq_if

`default_nettype wire

// ---- hw/pwr_seq_host.sv ----
/*
 * host end: issues commands, falls back to the reset pin on timeout,
 * and waits for the interface rail to drop to see power-off done.
 * assumes the device end answers over the shared interface.
 */
`timescale 1ns/100ps
`default_nettype none

module pwr_seq_host
    import pwr_seq_pkg::*;
#(
    parameter int unsigned RESP_TIMEOUT = 1000  // cycles to wait for OK
)
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // user requests, one-cycle pulses
    input wire logic req_in,
    input wire cmd_t req_cmd_in,
    input wire logic power_on_req_in,
    // link to device
    pwr_seq_if.host link,
    // user status
    output logic busy_out,
    output logic done_out,
    output logic forced_reset_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {H_IDLE, H_WAIT_OK, H_WAIT_RAIL, H_RESET, H_PON} hstate_t;
    typedef struct packed {
        hstate_t st;
        cmd_t cmd;
        logic [CNT_W-1:0] cnt;
        logic done;
        logic forced;
    } hst_t;

    hst_t h_r;
    hst_t h_nxt;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        h_nxt = h_r;
        h_nxt.done = 1'b0;
        h_nxt.cnt = h_r.cnt + CNT_W'(1);
        unique case (h_r.st)
            H_IDLE:
            begin
                h_nxt.cnt = '0;
                if (req_in)
                begin
                    h_nxt.st = H_WAIT_OK;
                    h_nxt.cmd = req_cmd_in;
                end
                else if (power_on_req_in)
                    h_nxt.st = H_PON;
            end
            H_WAIT_OK:
            begin
                if (link.cmd_ok)
                begin
                    h_nxt.cnt = '0;
                    h_nxt.st = (h_r.cmd == CMD_POWER_OFF) ? H_WAIT_RAIL : H_IDLE;
                    h_nxt.done = (h_r.cmd != CMD_POWER_OFF);
                end
                else if (h_r.cnt >= CNT_W'(RESP_TIMEOUT))
                begin
                    h_nxt.st = H_RESET;
                    h_nxt.cnt = '0;
                    h_nxt.forced = 1'b1;
                end
            end
            H_WAIT_RAIL:
            begin
                if (!link.vint_on)
                begin
                    h_nxt.st = H_IDLE;
                    h_nxt.done = 1'b1;
                end
            end
            H_RESET, H_PON:
            begin
                // hold the pin low just past the qualifying time
                if (h_r.cnt >= CNT_W'((h_r.st == H_RESET) ? RESET_MIN_CYC : POWER_ON_MIN_CYC))
                begin
                    h_nxt.st = H_IDLE;
                    h_nxt.done = 1'b1;
                end
            end
            default:
                h_nxt.st = H_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
            h_r <= '{st: H_IDLE, cmd: CMD_NONE, default: '0};
        else
            h_r <= h_nxt;
    end

    // ------------------------------------------------------------
    // outputs; command strobe issued only while the rail is up
    // ------------------------------------------------------------
    assign link.cmd_valid = (h_r.st == H_WAIT_OK) && (h_r.cnt == '0) && link.vint_on;
    assign link.cmd_code = h_r.cmd;
    assign link.hw_reset_oe = (h_r.st == H_RESET);
    assign link.power_on_oe = (h_r.st == H_PON);
    assign busy_out = (h_r.st != H_IDLE);
    assign done_out = h_r.done;
    assign forced_reset_out = h_r.forced;

endmodule : pwr_seq_host

`default_nettype wire

// ---- testbench/pwr_seq_props.sv ----
/*
 * concurrent checks on the host-device sequencing link.
 * assumes one clock, synchronous active-low reset, inputs wired to the link signals.
 */
`timescale 1ns/100ps
`default_nettype none

module pwr_seq_props
    import pwr_seq_pkg::*;
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // link signals
    input wire logic cmd_valid,
    input wire logic cmd_ok,
    input wire logic hw_reset_oe,
    input wire logic power_on_oe,
    input wire logic vint_on,
    input wire logic backup_rtc_supply,
    input wire logic pins_tristate,
    input wire logic main_supply
);
    // ------------------------------------------------------------
    // helper counters
    // ------------------------------------------------------------
    localparam int unsigned PULSE_CYC = RESET_MIN_CYC + 1; // pull-down stand time
    logic [7:0] rst_cnt_r; // cycles reset pin pulled low
    logic [7:0] pon_cnt_r; // cycles power-on pin pulled low

    // 8 bits suffice: pulses here never pass 255 cycles
    always_ff @(posedge mclk_in)
    begin
        rst_cnt_r <= hw_reset_oe ? rst_cnt_r + 8'h01 : 8'h00;
        pon_cnt_r <= power_on_oe ? pon_cnt_r + 8'h01 : 8'h00;
    end

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    chk_ok_follows_cmd: assert property (cmd_valid && vint_on |=> cmd_ok)
        else $error("no OK one cycle after a command");
    chk_ok_has_cause: assert property (cmd_ok |-> $past(cmd_valid))
        else $error("OK without a command");
    chk_cmd_one_cycle: assert property (cmd_valid |=> !cmd_valid)
        else $error("command strobe longer than one cycle");
    chk_cmd_needs_rail: assert property (cmd_valid |-> vint_on)
        else $error("command driven while rail off");
    chk_rail_off_tristate: assert property (!vint_on |-> pins_tristate)
        else $error("pins driven while rail off");
    chk_rail_keeps_backup: assert property (vint_on |-> backup_rtc_supply)
        else $error("backup supply off while rail on");
    chk_off_keeps_backup: assert property ($fell(vint_on) && main_supply |-> backup_rtc_supply)
        else $error("backup supply dropped at switch-off");
    chk_supply_loss_off: assert property (!main_supply |=> !vint_on && !backup_rtc_supply)
        else $error("supplies stay up without main supply");
    chk_reset_pulse_len: assert property ($fell(hw_reset_oe) |-> rst_cnt_r == 8'(PULSE_CYC))
        else $error("reset pull-down length wrong");
    chk_pon_pulse_len: assert property ($fell(power_on_oe) |-> pon_cnt_r == 8'(PULSE_CYC))
        else $error("power-on pull-down length wrong");
    chk_pon_rail_up: assert property ($fell(power_on_oe) && main_supply |-> ##[0:4] vint_on)
        else $error("rail not up after power-on pulse");

    // main scenarios reached
    cov_cmd_ok: cover property (cmd_ok);
    cov_switch_off: cover property ($fell(vint_on) && main_supply);
    cov_forced_reset: cover property ($fell(hw_reset_oe));
    cov_power_on: cover property ($fell(power_on_oe));
endmodule : pwr_seq_props

`default_nettype wire

// ---- testbench/module_poweroff_reset_sequencer_tb_top.sv ----
/*
 * self-checking bench: host end and device end joined by the link.
 * assumes the bench alone drives main supply, slow clock and host user requests.
 */
`timescale 1ns/100ps
`default_nettype none

module module_poweroff_reset_sequencer_tb_top
    import pwr_seq_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int unsigned RESP_TO = 40; // short host answer timeout
    localparam int unsigned SLOW_TO = 64; // short slow clock watchdog
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic req_in = 1'b0;
    cmd_t req_cmd_in = CMD_NONE;
    logic power_on_req_in = 1'b0;
    logic busy_out, done_out, forced_reset_out;
    logic [2:0] mode_out;
    logic core_reset_out, pmu_reset_out, save_settings_out, low_power_idle_out, rtc_running_out;
    int n_errors = 0;
    int samples_checked = 0;
    int cycle_cnt = 0; // hang guard
    logic [31:0] lfsr_r = 32'h6F84; // fixed seed
    logic slow_en = 1'b0; // slow clock stands still when low
    int slow_cnt = 0;
    int slow_half = 8; // half period, below the watchdog
    int k;

    pwr_seq_if pwr_seq_if_i ();
    pwr_seq_device #(.VARIANT_TWO(1'b0), .HAS_SLOW_CLK_IN(1'b1), .SLOW_FROM_OWN_OUT(1'b0),
        .SLOW_TIMEOUT(SLOW_TO)) pwr_seq_device_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .link(pwr_seq_if_i), .mode_out(mode_out), .core_reset_out(core_reset_out),
        .pmu_reset_out(pmu_reset_out), .save_settings_out(save_settings_out),
        .low_power_idle_out(low_power_idle_out), .rtc_running_out(rtc_running_out));
    pwr_seq_host #(.RESP_TIMEOUT(RESP_TO)) pwr_seq_host_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .req_in(req_in), .req_cmd_in(req_cmd_in), .power_on_req_in(power_on_req_in),
        .link(pwr_seq_if_i), .busy_out(busy_out), .done_out(done_out), .forced_reset_out(forced_reset_out));
    pwr_seq_props pwr_seq_props_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .cmd_valid(pwr_seq_if_i.cmd_valid),
        .cmd_ok(pwr_seq_if_i.cmd_ok), .hw_reset_oe(pwr_seq_if_i.hw_reset_oe),
        .power_on_oe(pwr_seq_if_i.power_on_oe), .vint_on(pwr_seq_if_i.vint_on),
        .backup_rtc_supply(pwr_seq_if_i.backup_rtc_supply), .pins_tristate(pwr_seq_if_i.pins_tristate),
        .main_supply(pwr_seq_if_i.main_supply));

    // ------------------------------------------------------------
    // clock, slow clock, hang guard
    // ------------------------------------------------------------
    always #4 mclk_in = ~mclk_in;

    // slow reference toggles only while enabled
    always @(posedge mclk_in)
    begin
        cycle_cnt <= cycle_cnt + 1;
        if (cycle_cnt == 20000)
        begin
            n_errors++;
            finish_test();
        end
        if (slow_en && slow_cnt >= slow_half)
        begin
            slow_cnt <= 0;
            pwr_seq_if_i.slow_clock_input <= ~pwr_seq_if_i.slow_clock_input;
        end
        else
            slow_cnt <= slow_cnt + 1;
    end

    // ------------------------------------------------------------
    // expectation and helper code
    // ------------------------------------------------------------
    // rail is up in every running mode; variant one keeps it through a hardware reset
    function automatic logic exp_rail(input mode_t m);
        return m inside {MODE_ACTIVE, MODE_SWITCH_OFF, MODE_SW_RESET, MODE_HW_RESET};
    endfunction : exp_rail

    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_step

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    task automatic idle(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask : idle

    // waits for a mode under a bound, then checks the supplies it implies
    task automatic wait_mode(input mode_t m, input int limit);
        int i;
        i = 0;
        while (mode_out !== m && i < limit)
        begin
            idle(1);
            i++;
        end
        check("mode_out", 8'(m), 8'(mode_out));
        check("vint_on", 8'(exp_rail(m)), 8'(pwr_seq_if_i.vint_on));
        check("pins_tristate", 8'(!exp_rail(m)), 8'(pwr_seq_if_i.pins_tristate));
        check("backup_rtc_supply", 8'(m != MODE_NOT_POWERED), 8'(pwr_seq_if_i.backup_rtc_supply));
    endtask : wait_mode

    // one user request once the host is free
    task automatic send(input cmd_t c);
        int i;
        i = 0;
        while (busy_out !== 1'b0 && i < 300)
        begin
            idle(1);
            i++;
        end
        @(posedge mclk_in);
        req_in <= 1'b1;
        req_cmd_in <= c;
        @(posedge mclk_in);
        req_in <= 1'b0;
        #1;
    endtask : send

    task automatic finish_test();
        $display("checked %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        pwr_seq_if_i.main_supply = 1'b1;
        pwr_seq_if_i.slow_clock_input = 1'b0;
        lfsr_r = lfsr_step(lfsr_r);
        slow_half = 8 + int'(lfsr_r[3:0]);
        idle(3);
        rst_n_in <= 1'b1;
        wait_mode(MODE_POWER_OFF, 4);
        $display("test reset done");
        // power-on pulse from the host
        @(posedge mclk_in);
        power_on_req_in <= 1'b1;
        @(posedge mclk_in);
        power_on_req_in <= 1'b0;
        wait_mode(MODE_ACTIVE, 80);
        $display("test power_on done");
        // low-power idle only with saving enabled and the slow clock running
        slow_en <= 1'b1;
        idle(30);
        check("low_power_idle_out", 8'h00, 8'(low_power_idle_out));
        send(CMD_POWER_SAVE);
        idle(30);
        check("low_power_idle_out", 8'h01, 8'(low_power_idle_out));
        check("rtc_running_out", 8'h01, 8'(rtc_running_out));
        slow_en <= 1'b0;
        idle(SLOW_TO + 40);
        check("low_power_idle_out", 8'h00, 8'(low_power_idle_out));
        check("rtc_running_out", 8'h00, 8'(rtc_running_out));
        $display("test slow_clock done");
        // functionality reset saves then returns
        send(CMD_FUNC_RESET);
        wait_mode(MODE_SW_RESET, 4);
        check("save_settings_out", 8'h01, 8'(save_settings_out));
        wait_mode(MODE_ACTIVE, SAVE_CYC + 8);
        $display("test func_reset done");
        // power-off: OK while routine runs, then rails down
        send(CMD_POWER_OFF);
        wait_mode(MODE_SWITCH_OFF, 4);
        check("save_settings_out", 8'h01, 8'(save_settings_out));
        wait_mode(MODE_POWER_OFF, SAVE_CYC + 8);
        k = 0;
        while (done_out !== 1'b1 && k < 8)
        begin
            idle(1);
            k++;
        end
        check("done_out", 8'h01, 8'(done_out));
        // stays off for a random time; external slow clock keeps rtc alive
        slow_en <= 1'b1;
        lfsr_r = lfsr_step(lfsr_r);
        idle(40 + int'(lfsr_r[5:0]));
        wait_mode(MODE_POWER_OFF, 0);
        check("rtc_running_out", 8'h01, 8'(rtc_running_out));
        $display("test power_off done");
        // refused command: host times out and pulls reset, device starts up
        send(CMD_POWER_SAVE);
        wait_mode(MODE_ACTIVE, RESP_TO + 120);
        check("forced_reset_out", 8'h01, 8'(forced_reset_out));
        check("save_settings_out", 8'h00, 8'(save_settings_out));
        check("pmu_reset_out", 8'h00, 8'(pmu_reset_out));
        $display("test forced_reset done");
        // supply removed
        @(posedge mclk_in);
        pwr_seq_if_i.main_supply <= 1'b0;
        wait_mode(MODE_NOT_POWERED, 4);
        $display("test supply_loss done");
        finish_test();
    end
endmodule : module_poweroff_reset_sequencer_tb_top

`default_nettype wire
